// *** design/dba_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none

module dba_arbiter
  import dba_pkg::*;
#(
  parameter int unsigned ROW_WORDS = DBA_ROW_WORDS,
  parameter int unsigned ROW_GAP   = DBA_ROW_GAP,
  parameter int unsigned BUF_DEPTH = DBA_BUF_DEPTH
) (
  input  wire logic                  CLOCK,
  input  wire logic                  NRST,
  input  wire logic                  TRANSFER_BUS_CLOCK,
  input  wire logic                  HOST_CTRL_REQUEST,
  input  wire logic                  AUDIO_REQUEST,
  output logic                       HOST_CTRL_GRANT,
  output logic                       AUDIO_GRANT,
  output logic                       ANY_REQUEST,
  input  wire logic                  FRAME,
  input  wire logic                  IRDY,
  output logic                       TRDY,
  input  wire logic                  TRANSFER_DIRECTION,
  input  wire logic [DBA_DATA_W-1:0] ADDR_WDATA_BUS,
  input  wire logic [DBA_LANE_W-1:0] LENGTH_BYTE_LANES,
  output logic [DBA_DATA_W-1:0]      READ_DATA_BUS,
  output logic                       MEM_WR_VALID,
  input  wire logic                  MEM_WR_READY,
  output logic [DBA_DATA_W-1:0]      MEM_WR_ADDR,
  output logic [DBA_DATA_W-1:0]      MEM_WR_DATA,
  output logic [DBA_LANE_W-1:0]      MEM_WR_LANES,
  output logic                       MEM_RD_REQ,
  input  wire logic                  MEM_RD_ACCEPT,
  output logic [DBA_DATA_W-1:0]      MEM_RD_ADDR,
  input  wire logic                  MEM_RD_VALID,
  input  wire logic [DBA_DATA_W-1:0] MEM_RD_DATA,
  output logic                       MEM_RD_READY
);

  localparam int unsigned ROW_BITS = $clog2(ROW_WORDS);
  localparam int unsigned CW       = $clog2(BUF_DEPTH + 1);
  localparam int unsigned GW       = $clog2(ROW_GAP + 1);

  dba_arb_e              arb_state;
  dba_tgt_e              tgt_state;
  logic                  dead_high;
  logic                  done_seen;
  logic                  granted;
  logic                  arb_update;
  logic                  xfer_write;
  logic [DBA_DATA_W-1:0] bus_addr;
  logic [DBA_CNT_W-1:0]  burst_len;
  logic [DBA_CNT_W-1:0]  words_done;
  logic [DBA_CNT_W-1:0]  reqs_issued;
  logic [CW-1:0]         outstanding;
  logic [GW-1:0]         row_stall;
  logic                  start;
  logic                  word_take;
  logic                  rd_take;
  logic                  rd_return;
  logic                  done;
  logic                  stall_trig;
  logic                  buf_in_valid;
  logic                  buf_in_ready;
  logic [DBA_BUF_W-1:0]  buf_in_data;
  logic                  buf_out_valid;
  logic                  buf_out_ready;
  logic [DBA_BUF_W-1:0]  buf_out_data;
  logic [CW-1:0]         buf_count;

  // length field 0..15 encodes bursts of 1..16 words
  function automatic logic [DBA_CNT_W-1:0] len_decode(input logic [DBA_LANE_W-1:0] f);
    return {1'b0, f} + DBA_CNT_W'(1);
  endfunction : len_decode
  function automatic logic row_start(input logic [DBA_DATA_W-1:0] a);
    return (a[ROW_BITS+1:2] == '0);
  endfunction : row_start
  function automatic logic [DBA_DATA_W-1:0] next_word(input logic [DBA_DATA_W-1:0] a);
    return a + DBA_DATA_W'(DBA_WORD_BYTES);
  endfunction : next_word

  assign ANY_REQUEST = HOST_CTRL_REQUEST | AUDIO_REQUEST;
  assign granted     = HOST_CTRL_GRANT | AUDIO_GRANT;
  // transfer bus clock is sampled; grants only move in its low phase
  assign arb_update  = !TRANSFER_BUS_CLOCK;

  // arbitration: two states, grant flops written only here
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      arb_state       <= ARB_GRANTED;
      HOST_CTRL_GRANT <= 1'b0;
      AUDIO_GRANT     <= 1'b1;
    end else if (arb_update) begin
      case (arb_state)
        ARB_GRANTED: begin
          // release only after a finished transfer, or an idle audio park
          if (done_seen ||
              (AUDIO_GRANT && HOST_CTRL_REQUEST && !FRAME && tgt_state == TGT_IDLE)) begin
            arb_state       <= ARB_DEAD;
            HOST_CTRL_GRANT <= 1'b0;
            AUDIO_GRANT     <= 1'b0;
          end
        end
        ARB_DEAD: begin
          if (dead_high) begin
            arb_state       <= ARB_GRANTED;
            HOST_CTRL_GRANT <= HOST_CTRL_REQUEST;
            AUDIO_GRANT     <= !HOST_CTRL_REQUEST;
          end
        end
        default: begin
          arb_state       <= ARB_DEAD;
          HOST_CTRL_GRANT <= 1'b0;
          AUDIO_GRANT     <= 1'b0;
        end
      endcase
    end
  end

  // dead phase must see a whole high phase of the bus clock with no grant
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      dead_high <= 1'b0;
    end else if (arb_state != ARB_DEAD) begin
      dead_high <= 1'b0;
    end else if (TRANSFER_BUS_CLOCK) begin
      dead_high <= 1'b1;
    end
  end

  // done may pulse during the high phase; hold it until the arbiter looks
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      done_seen <= 1'b0;
    end else if (done) begin
      done_seen <= 1'b1;
    end else if (arb_update && arb_state == ARB_GRANTED) begin
      done_seen <= 1'b0;
    end
  end

  // target side: a new burst waits until all old words are gone
  assign start = (tgt_state == TGT_IDLE) && FRAME && granted &&
                 (buf_count == '0) && (outstanding == '0);
  assign TRDY  = (tgt_state == TGT_DATA) && (row_stall == '0) &&
                 (words_done < burst_len) &&
                 (xfer_write ? buf_in_ready : buf_out_valid);
  assign word_take = (tgt_state == TGT_DATA) && IRDY && TRDY;
  assign done = (tgt_state == TGT_DATA) && !FRAME &&
                (!IRDY || word_take || words_done == burst_len);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      tgt_state  <= TGT_IDLE;
      xfer_write <= DBA_DIR_READ;
      burst_len  <= '0;
    end else if (start) begin
      tgt_state  <= TGT_DATA;
      xfer_write <= TRANSFER_DIRECTION;
      burst_len  <= len_decode(LENGTH_BYTE_LANES);
    end else if (done) begin
      tgt_state  <= TGT_IDLE;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      bus_addr   <= '0;
      words_done <= '0;
    end else if (start) begin
      bus_addr   <= ADDR_WDATA_BUS;
      words_done <= '0;
    end else if (word_take) begin
      bus_addr   <= next_word(bus_addr);
      words_done <= words_done + DBA_CNT_W'(1);
    end
  end

  // read requests toward memory, limited by buffer room in flight
  assign MEM_RD_REQ = (tgt_state == TGT_DATA) && !xfer_write && (row_stall == '0) &&
                      (reqs_issued < burst_len) &&
                      ({1'b0, outstanding} + {1'b0, buf_count} < (CW + 1)'(BUF_DEPTH));
  assign rd_take    = MEM_RD_REQ && MEM_RD_ACCEPT;
  // stray words returning after an early end are drained and dropped; words already in the buffer stay
  assign MEM_RD_READY = !xfer_write && ((tgt_state == TGT_IDLE) || buf_in_ready);
  assign rd_return  = MEM_RD_VALID && MEM_RD_READY;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      MEM_RD_ADDR <= '0;
      reqs_issued <= '0;
    end else if (start) begin
      MEM_RD_ADDR <= ADDR_WDATA_BUS;
      reqs_issued <= '0;
    end else if (rd_take) begin
      MEM_RD_ADDR <= next_word(MEM_RD_ADDR);
      reqs_issued <= reqs_issued + DBA_CNT_W'(1);
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      outstanding <= '0;
    end else if (rd_take && !rd_return) begin
      outstanding <= outstanding + CW'(1);
    end else if (rd_return && !rd_take) begin
      outstanding <= outstanding - CW'(1);
    end
  end

  // pause sits on the bus at the row crossing, either direction; costs ROW_GAP cycles
  assign stall_trig = word_take && row_start(next_word(bus_addr));

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      row_stall <= '0;
    end else if (stall_trig) begin
      row_stall <= GW'(ROW_GAP);
    end else if (row_stall != '0) begin
      row_stall <= row_stall - GW'(1);
    end
  end

  // one buffer serves both directions; its far side can stall
  assign buf_in_valid  = xfer_write ? word_take : (MEM_RD_VALID && tgt_state == TGT_DATA);
  assign buf_in_data   = xfer_write ? {bus_addr, LENGTH_BYTE_LANES, ADDR_WDATA_BUS}
                                    : {DBA_DATA_W'(0), DBA_LANE_W'(0), MEM_RD_DATA};
  assign buf_out_ready = xfer_write ? MEM_WR_READY : word_take;
  assign MEM_WR_VALID  = xfer_write && buf_out_valid;
  assign MEM_WR_DATA   = buf_out_data[DBA_DATA_W-1:0];
  assign MEM_WR_LANES  = buf_out_data[DBA_DATA_W+DBA_LANE_W-1:DBA_DATA_W];
  assign MEM_WR_ADDR   = buf_out_data[DBA_BUF_W-1:DBA_DATA_W+DBA_LANE_W];
  assign READ_DATA_BUS = buf_out_data[DBA_DATA_W-1:0];

  dba_buffer #(
    .WIDTH (DBA_BUF_W),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clock     (CLOCK),
    .nrst      (NRST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data),
    .count     (buf_count)
  );

  sequence s_dead_ready;
    arb_state == ARB_DEAD && dead_high && arb_update;
  endsequence
  sequence s_busy_grant;
    tgt_state == TGT_DATA && granted;
  endsequence

  a_any_req_or: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    ANY_REQUEST == (HOST_CTRL_REQUEST || AUDIO_REQUEST))
    else $error("any request differs from or of requests");

  a_grant_one_owner: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    !(HOST_CTRL_GRANT && AUDIO_GRANT))
    else $error("both grants high");

  a_grant_low_phase: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    ($changed(HOST_CTRL_GRANT) || $changed(AUDIO_GRANT)) |-> !$past(TRANSFER_BUS_CLOCK))
    else $error("grant moved in high phase");

  a_dead_gap_kept: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    ($rose(HOST_CTRL_GRANT) || $rose(AUDIO_GRANT)) |->
      $past(arb_state) == ARB_DEAD && $past(dead_high))
    else $error("grant without dead cycle");

  a_no_preempt: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    s_busy_grant |=> granted)
    else $error("grant lost during transfer");

  a_host_priority: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    s_dead_ready ##0 HOST_CTRL_REQUEST |=> HOST_CTRL_GRANT && !AUDIO_GRANT)
    else $error("host request not granted first");

  a_park_audio: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    s_dead_ready ##0 !HOST_CTRL_REQUEST |=> AUDIO_GRANT)
    else $error("grant not parked on audio");

  a_reset_audio: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    $rose(NRST) |-> AUDIO_GRANT && !HOST_CTRL_GRANT)
    else $error("audio not owner after reset");

  a_row_stall_trdy: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    stall_trig |=> !TRDY [*2])
    else $error("target ready during row change");

  a_burst_limit: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    words_done <= DBA_CNT_W'(DBA_MAX_BURST) && words_done <= burst_len)
    else $error("burst longer than allowed");

  a_write_room: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    TRDY && xfer_write |-> buf_in_ready && buf_count < CW'(BUF_DEPTH))
    else $error("write ready without room");

  a_release_done: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    done |-> ##[1:1000] arb_state == ARB_DEAD)
    else $error("grant not released after transfer");

endmodule : dba_arbiter

`default_nettype wire

// *** design/dba_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

module dba_buffer #(
  parameter int unsigned WIDTH = 68,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction : ptr_inc

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end

endmodule : dba_buffer

`default_nettype wire

// *** design/dba_pkg.sv ***
package dba_pkg;

  localparam int unsigned DBA_DATA_W    = 32;
  localparam int unsigned DBA_LANE_W    = 4;
  localparam int unsigned DBA_MAX_BURST = 16;
  localparam int unsigned DBA_ROW_WORDS = 256;
  localparam int unsigned DBA_ROW_GAP   = 4;
  localparam int unsigned DBA_BUF_DEPTH = 2;
  localparam int unsigned DBA_WORD_BYTES = 4;
  localparam int unsigned DBA_CNT_W     = 5;

  localparam logic        DBA_DIR_READ  = 1'b0;
  localparam logic        DBA_DIR_WRITE = 1'b1;

  // buffer word: address, byte lanes, data (reads use the data field only)
  localparam int unsigned DBA_BUF_W = 2 * DBA_DATA_W + DBA_LANE_W;

  typedef enum logic {ARB_GRANTED, ARB_DEAD} dba_arb_e;
  typedef enum logic {TGT_IDLE, TGT_DATA} dba_tgt_e;

endpackage : dba_pkg

// *** verif/dba_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// memory behind the target: write sink and read source, optionally slow
module dba_mem_model
  import dba_pkg::*;
(
  input  wire logic                  CLOCK,
  input  wire logic                  NRST,
  input  wire logic                  slow,
  input  wire logic                  MEM_WR_VALID,
  output logic                       MEM_WR_READY,
  input  wire logic [DBA_DATA_W-1:0] MEM_WR_ADDR,
  input  wire logic [DBA_DATA_W-1:0] MEM_WR_DATA,
  input  wire logic [DBA_LANE_W-1:0] MEM_WR_LANES,
  input  wire logic                  MEM_RD_REQ,
  output logic                       MEM_RD_ACCEPT,
  input  wire logic [DBA_DATA_W-1:0] MEM_RD_ADDR,
  output logic                       MEM_RD_VALID,
  output logic [DBA_DATA_W-1:0]      MEM_RD_DATA,
  input  wire logic                  MEM_RD_READY
);
  logic [DBA_DATA_W-1:0] mem [64];
  logic [DBA_DATA_W-1:0] q [$];
  logic [DBA_DATA_W-1:0] a;
  logic [3:0]            tick;
  int                    wait_n;

  // slow mode stalls writes three cycles in four, read requests every other
  assign MEM_WR_READY  = !slow || tick[1:0] == 2'h0;
  assign MEM_RD_ACCEPT = !slow || tick[0];

  initial begin
    for (int i = 0; i < 64; i++)
      mem[i] = 32'h1000_0000 + i * 32'h0000_0101;
  end

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      q.delete();
      tick <= 4'h0;
      wait_n <= 0;
      MEM_RD_VALID <= 1'b0;
      MEM_RD_DATA <= 32'h0;
    end else begin
      tick <= tick + 4'h1;
      if (MEM_WR_VALID && MEM_WR_READY) begin
        for (int b = 0; b < 4; b++)
          if (MEM_WR_LANES[b])
            mem[MEM_WR_ADDR[7:2]][8*b+:8] <= MEM_WR_DATA[8*b+:8];
      end
      if (MEM_RD_REQ && MEM_RD_ACCEPT)
        q.push_back(MEM_RD_ADDR);
      if (MEM_RD_VALID && MEM_RD_READY) begin
        MEM_RD_VALID <= 1'b0;
        // never leave the old word showing once taken
        MEM_RD_DATA <= ~MEM_RD_DATA;
      end else if (!MEM_RD_VALID && q.size() > 0) begin
        if (wait_n >= (slow ? 5 : 0)) begin
          a = q.pop_front();
          MEM_RD_VALID <= 1'b1;
          MEM_RD_DATA <= mem[a[7:2]];
          wait_n <= 0;
        end else begin
          wait_n <= wait_n + 1;
        end
      end
    end
  end
endmodule : dba_mem_model

`default_nettype wire

// *** verif/test_dma_bus_arbiter_handshake.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_dma_bus_arbiter_handshake
  import dba_pkg::*;
;
  localparam int RW = 4;
  logic        clock = 1'b0, nrst = 1'b1, bclk = 1'b0, bc = 1'b0, slow = 1'b0;
  logic        hreq = 1'b0, areq = 1'b0, frame = 1'b0, irdy = 1'b0, dir = 1'b0;
  logic        hgnt, agnt, anyr, trdy, wv, rq, rrdy, rv, wrdy, racc;
  logic [31:0] adw = 32'h0;
  logic [3:0]  lbl = 4'h0;
  logic [31:0] rdb, wa, wd, ra, rd;
  logic [3:0]  wl;
  logic [31:0] sh [64];
  logic [1:0]  pg = 2'b01;
  int          err_total = 0, cmp_count = 0, cyc = 0;

  dba_arbiter #(.ROW_WORDS(RW)) dut (.CLOCK(clock), .NRST(nrst), .TRANSFER_BUS_CLOCK(bclk),
    .HOST_CTRL_REQUEST(hreq), .AUDIO_REQUEST(areq), .HOST_CTRL_GRANT(hgnt),
    .AUDIO_GRANT(agnt), .ANY_REQUEST(anyr), .FRAME(frame), .IRDY(irdy), .TRDY(trdy),
    .TRANSFER_DIRECTION(dir), .ADDR_WDATA_BUS(adw), .LENGTH_BYTE_LANES(lbl),
    .READ_DATA_BUS(rdb), .MEM_WR_VALID(wv), .MEM_WR_READY(wrdy), .MEM_WR_ADDR(wa),
    .MEM_WR_DATA(wd), .MEM_WR_LANES(wl), .MEM_RD_REQ(rq), .MEM_RD_ACCEPT(racc),
    .MEM_RD_ADDR(ra), .MEM_RD_VALID(rv), .MEM_RD_DATA(rd), .MEM_RD_READY(rrdy));

  dba_mem_model mem (.CLOCK(clock), .NRST(nrst), .slow(slow), .MEM_WR_VALID(wv),
    .MEM_WR_READY(wrdy), .MEM_WR_ADDR(wa), .MEM_WR_DATA(wd), .MEM_WR_LANES(wl),
    .MEM_RD_REQ(rq), .MEM_RD_ACCEPT(racc), .MEM_RD_ADDR(ra), .MEM_RD_VALID(rv),
    .MEM_RD_DATA(rd), .MEM_RD_READY(rrdy));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  always #2.5 clock = ~clock;

  // bus clock at half rate; sampled value kept for the grant-phase check
  always @(posedge clock) begin
    bc = bclk;
    cyc++;
    #1 bclk = ~bclk;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  always @(negedge clock) begin
    if (nrst && {hgnt, agnt} !== pg) begin
      chk(32'h0, bc);
      chk(32'h1, pg == 2'b00 || {hgnt, agnt} == 2'b00);
    end
    if (nrst)
      chk(hreq | areq, anyr);
    pg = {hgnt, agnt};
  end

  task automatic wait_gnt(input logic h);
    int c;
    c = 0;
    while ((h ? hgnt : agnt) !== 1'b1 && c < 100) begin
      @(posedge clock);
      #1;
      c++;
    end
    chk(32'h1, h ? hgnt : agnt);
  endtask : wait_gnt

  // returns cycles spent with target ready low before the word moved
  task automatic hs(output int g, output logic [31:0] d);
    logic t;
    g = 0;
    do begin
      @(negedge clock);
      t = trdy;
      d = rdb;
      @(posedge clock);
      if (t !== 1'b1)
        g++;
    end while (t !== 1'b1 && g < 200);
    // a word that never moves counts as a mismatch
    chk(32'h1, t);
    #1;
  endtask : hs

  task automatic xfer(input logic h, input logic d, input logic [31:0] a, input int n,
                      input logic [3:0] ln);
    int          g;
    logic [31:0] v, w;
    repeat (16) @(posedge clock);
    #1;
    if (h)
      hreq = 1'b1;
    else
      areq = 1'b1;
    wait_gnt(h);
    if (h)
      hreq = 1'b0;
    else
      areq = 1'b0;
    frame = 1'b1;
    dir = d;
    adw = a;
    lbl = 4'(n - 1);
    @(posedge clock);
    #1;
    for (int i = 0; i < n; i++) begin
      w = a + 32'(4 * i);
      if (i == 1) begin
        irdy = 1'b0;
        repeat (2) @(posedge clock);
        #1;
      end
      irdy = 1'b1;
      frame = (i != n - 1);
      adw = 32'hD000_0000 + w;
      lbl = ln;
      chk(32'h1, h ? hgnt : agnt);
      chk(32'h0, h ? agnt : hgnt);
      hs(g, v);
      if (i > 0 && w % (4 * RW) == 0)
        chk(32'h1, g >= DBA_ROW_GAP);
      if (d) begin
        for (int b = 0; b < 4; b++)
          if (ln[b])
            sh[w[7:2]][8*b+:8] = adw[8*b+:8];
      end else begin
        chk(sh[w[7:2]], v);
      end
    end
    // parked audio keeps idle levels driven; released lines never keep the old word
    irdy = 1'b0;
    adw = ~adw;
  endtask : xfer

  task automatic t_reset();
    repeat (6) @(posedge clock);
    chk(32'h1, agnt);
    chk(32'h0, hgnt);
    chk(32'h0, trdy);
    #1;
    nrst = 1'b1;
    $display("reset test done");
  endtask : t_reset

  task automatic t_write_read();
    slow = 1'b1;
    xfer(1'b0, 1'b1, 32'h8, 8, 4'hF);
    xfer(1'b0, 1'b1, 32'h20, 1, 4'h5);
    xfer(1'b0, 1'b0, 32'h8, 8, 4'h0);
    xfer(1'b0, 1'b0, 32'h20, 1, 4'h0);
    $display("write read test done");
  endtask : t_write_read

  task automatic t_burst();
    slow = 1'b0;
    xfer(1'b0, 1'b1, 32'h40, 16, 4'hF);
    xfer(1'b0, 1'b0, 32'h40, 16, 4'h0);
    $display("burst test done");
  endtask : t_burst

  task automatic t_prio();
    slow = 1'b1;
    repeat (16) @(posedge clock);
    #1;
    hreq = 1'b1;
    areq = 1'b1;
    wait_gnt(1'b1);
    xfer(1'b1, 1'b0, 32'h8, 4, 4'h0);
    wait_gnt(1'b0);
    areq = 1'b0;
    $display("priority test done");
  endtask : t_prio

  task automatic t_park();
    repeat (16) @(posedge clock);
    chk(32'h1, agnt);
    #1;
    hreq = 1'b1;
    wait_gnt(1'b1);
    hreq = 1'b0;
    repeat (20) @(posedge clock);
    chk(32'h1, hgnt);
    #1;
    nrst = 1'b0;
    #1;
    chk(32'h1, agnt);
    chk(32'h0, hgnt);
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'b1;
    $display("park test done");
  endtask : t_park

  initial begin
    for (int i = 0; i < 64; i++)
      sh[i] = 32'h1000_0000 + i * 32'h0000_0101;
    #1;
    nrst = 1'b0;
    t_reset();
    t_write_read();
    t_burst();
    t_prio();
    t_park();
    end_sim();
  end
endmodule : test_dma_bus_arbiter_handshake

`default_nettype wire
